// *** hdl/table_jump_and_pair_move_unit.v ***
// Execution unit for pop-and-return, pair moves and table jumps
//
// Overview of operation
// - Reload listed registers downward, one word each
// - Reload replayable; sp update and return atomic
// - Equal saved targets make move illegal
// - Move a0,a1 into two saved registers together
// - Move two saved registers into a0,a1 together
// - Specifier maps to x8, x9, x18..x23
// - Reduced base: specifier above one reserved
// - Table holds 256 native word entries
// - Table entries follow data byte order
// - Linking table jump pushes return stack
// - Both fetches checked for execute only
// - Table entry fetch skips triggers
// - Fetch fault traps at jump address
// - Table control register at address 0x017
// - Base always 64-byte aligned, virtual address
// - Only implemented modes stored
// - Reserved mode makes table jumps reserved
// - State enable bit 2 gates lower privilege
// - Index below 32 plain, else linking
// - Entry address is base plus shifted index
// - Plain jump to entry, bit 0 cleared
// - Entries fetched fresh
// - Linking jump writes ra and jumps in the same cycle
`default_nettype none
`include "tjpm_consts.vh"

module table_jump_and_pair_move_unit #(
   parameter W = 32,
   parameter [5:0] MODE_MASK = 6'h00,
   parameter [4:0] ILLEGAL_CAUSE = 5'h02,
   parameter [4:0] VIRTUAL_CAUSE = 5'h16
) (
   input wire clock_i,
   input wire resetn_i,
   // Issue port
   input wire issue_valid_i,
   input wire [15:0] issue_instr_i,
   input wire [W-1:0] issue_pc_i,
   input wire issue_pop_i,
   input wire [3:0] issue_rlist_i,
   input wire [8:0] issue_stack_adj_i,
   input wire issue_fault_i,
   input wire [4:0] issue_fault_cause_i,
   output reg issue_ready_o,
   output reg done_o,
   output reg replay_o,
   // Core configuration and status
   input wire reduced_register_base_i,
   input wire data_big_endian_i,
   input wire lower_priv_i,
   input wire state_enable_bit2_i,
   input wire virtual_mode_i,
   input wire irq_pending_i,
   // Register file
   output reg [4:0] rf_raddr0_o,
   output reg [4:0] rf_raddr1_o,
   input wire [W-1:0] rf_rdata0_i,
   input wire [W-1:0] rf_rdata1_i,
   output reg rf_we0_o,
   output reg [4:0] rf_waddr0_o,
   output reg [W-1:0] rf_wdata0_o,
   output reg rf_we1_o,
   output reg [4:0] rf_waddr1_o,
   output reg [W-1:0] rf_wdata1_o,
   // Memory path
   output reg mem_req_o,
   output reg [W-1:0] mem_addr_o,
   output reg mem_ifetch_o,
   output reg mem_no_trigger_o,
   input wire mem_rvalid_i,
   input wire [W-1:0] mem_rdata_i,
   input wire mem_fault_i,
   input wire [4:0] mem_fault_cause_i,
   // Redirect and return stack
   output reg branch_valid_o,
   output reg [W-1:0] branch_target_o,
   output reg ras_push_o,
   // Trap report
   output reg trap_valid_o,
   output reg [W-1:0] trap_pc_o,
   output reg [4:0] trap_cause_o,
   output reg [W-1:0] trap_value_o,
   // Control register port
   input wire csr_valid_i,
   input wire csr_we_i,
   input wire [11:0] csr_addr_i,
   input wire [W-1:0] csr_wdata_i,
   output reg csr_ack_o,
   output reg csr_illegal_o,
   output reg [W-1:0] csr_rdata_o
);

   // Native word geometry
   localparam [W-1:0] BSTEP = W / 8;
   localparam SHIFT = (W == 32) ? `SHIFT32 : `SHIFT64;

   // One-hot states
   localparam [4:0] S_IDLE = 5'h01;
   localparam [4:0] S_POP_SP = 5'h02;
   localparam [4:0] S_POP_LD = 5'h04;
   localparam [4:0] S_PAIR = 5'h08;
   localparam [4:0] S_TJ = 5'h10;

   // Saved index 0..11 to register number
   function [4:0] sreg_num;
      input [3:0] j;
      begin
         sreg_num = (j < 4'h2) ? {1'b0, 4'h8 + j} : {1'b1, j};
      end
   endfunction

   // Reverse byte order of a native word
   function [W-1:0] byte_swap;
      input [W-1:0] v;
      integer i;
      begin
         byte_swap = {W{1'b0}};
         for (i = 0; i < W / 8; i = i + 1) begin
            byte_swap[8*i +: 8] = v[W-8-8*i +: 8];
         end
      end
   endfunction

   reg [4:0] state_ff; // Sequencer state
   reg [W-1:0] pc_ff; // Address of the instruction in flight
   reg [W-1:0] new_sp_ff; // Stack pointer after the frame is dropped
   reg [3:0] sidx_ff; // Saved registers still to load; 0 means ra
   reg [8:0] adj_ff; // Frame size
   reg link_ff; // Linking table jump
   reg to_saved_ff; // Pair move direction
   reg [4:0] r1_ff; // First saved register number
   reg [4:0] r2_ff; // Second saved register number
   reg [W-7:0] base_ff; // Table base above bit 5
   reg [5:0] mode_ff; // Table mode

   wire dec_to_saved; // Decoded move to saved
   wire dec_to_args; // Decoded move to arguments
   wire dec_tj_plain; // Decoded plain table jump
   wire dec_tj_link; // Decoded linking table jump
   wire [7:0] dec_index; // Table index
   wire [4:0] dec_r1; // First register number
   wire [4:0] dec_r2; // Second register number
   wire dec_pair_bad; // Illegal pair move encoding

   pair_and_table_decode u_decode (
      .instr_i(issue_instr_i),
      .reduced_base_i(reduced_register_base_i),
      .move_args_to_saved_o(dec_to_saved),
      .move_saved_to_args_o(dec_to_args),
      .table_jump_plain_o(dec_tj_plain),
      .table_jump_link_o(dec_tj_link),
      .index_o(dec_index),
      .first_reg_o(dec_r1),
      .second_reg_o(dec_r2),
      .pair_illegal_o(dec_pair_bad)
   );

   wire gate_block; // Lower privilege blocked by state enable
   wire [W-1:0] nxt_entry_addr; // Table entry address
   wire [W-1:0] nxt_entry; // Entry in native order
   wire [W-1:0] adj_w; // Frame size at native width
   wire [4:0] cur_reg; // Register loaded by the current pop load

   assign gate_block = lower_priv_i && !state_enable_bit2_i;
   assign nxt_entry_addr = {base_ff, {`BASE_ALIGN_BITS{1'b0}}} +
      {{(W-8-SHIFT){1'b0}}, dec_index, {SHIFT{1'b0}}};
   // Fetch bytes arrive little-endian
   assign nxt_entry = data_big_endian_i ? byte_swap(mem_rdata_i) : mem_rdata_i;
   assign adj_w = {{(W-9){1'b0}}, adj_ff};
   // Highest saved register first, ra last
   assign cur_reg = (sidx_ff == 4'h0) ? `REG_RA : sreg_num(sidx_ff - 4'h1);

   // Control register, legalised writes
   always @(posedge clock_i) begin
      csr_ack_o <= 1'b0;
      csr_illegal_o <= 1'b0;
      if (!resetn_i) begin
         base_ff <= {(W-6){1'b0}};
         mode_ff <= `MODE_TABLE_JUMP;
         csr_rdata_o <= {W{1'b0}};
      end else if (csr_valid_i && (csr_addr_i == `CSR_TABLE_CTRL)) begin
         csr_ack_o <= 1'b1;
         if (gate_block) begin
            csr_illegal_o <= 1'b1;
         end else begin
            csr_rdata_o <= {base_ff, mode_ff};
            if (csr_we_i) begin
               // Low six bits never reach the base, so alignment holds
               base_ff <= csr_wdata_i[W-1:`BASE_ALIGN_BITS];
               // Unimplemented mode bits read back as zero
               mode_ff <= csr_wdata_i[5:0] & MODE_MASK;
            end
         end
      end
   end

   // Instruction sequencer
   always @(posedge clock_i) begin
      done_o <= 1'b0;
      replay_o <= 1'b0;
      rf_we0_o <= 1'b0;
      rf_we1_o <= 1'b0;
      branch_valid_o <= 1'b0;
      ras_push_o <= 1'b0;
      trap_valid_o <= 1'b0;
      if (!resetn_i) begin
         state_ff <= S_IDLE;
         issue_ready_o <= 1'b1;
         pc_ff <= {W{1'b0}};
         new_sp_ff <= {W{1'b0}};
         sidx_ff <= 4'h0;
         adj_ff <= 9'h000;
         link_ff <= 1'b0;
         to_saved_ff <= 1'b0;
         r1_ff <= 5'h00;
         r2_ff <= 5'h00;
         rf_raddr0_o <= 5'h00;
         rf_raddr1_o <= 5'h00;
         rf_waddr0_o <= 5'h00;
         rf_wdata0_o <= {W{1'b0}};
         rf_waddr1_o <= 5'h00;
         rf_wdata1_o <= {W{1'b0}};
         mem_req_o <= 1'b0;
         mem_addr_o <= {W{1'b0}};
         mem_ifetch_o <= 1'b0;
         mem_no_trigger_o <= 1'b0;
         branch_target_o <= {W{1'b0}};
         trap_pc_o <= {W{1'b0}};
         trap_cause_o <= 5'h00;
         trap_value_o <= {W{1'b0}};
      end else begin
         case (state_ff)
            S_IDLE: begin
               if (issue_valid_i) begin
                  pc_ff <= issue_pc_i;
                  trap_pc_o <= issue_pc_i;
                  trap_value_o <= {{(W-16){1'b0}}, issue_instr_i};
                  trap_cause_o <= ILLEGAL_CAUSE;
                  if (issue_fault_i) begin
                     // Opcode fetch fault
                     trap_valid_o <= 1'b1;
                     trap_cause_o <= issue_fault_cause_i;
                     trap_value_o <= issue_pc_i;
                  end else if (issue_pop_i) begin
                     if (issue_rlist_i < `RLIST_MIN) begin
                        trap_valid_o <= 1'b1;
                     end else begin
                        // Fetch sp first; loads start from its value
                        adj_ff <= issue_stack_adj_i;
                        sidx_ff <= (issue_rlist_i == `RLIST_ALL) ? `SREG_ALL :
                           issue_rlist_i - `RLIST_MIN;
                        rf_raddr0_o <= `REG_SP;
                        state_ff <= S_POP_SP;
                        issue_ready_o <= 1'b0;
                     end
                  end else if (dec_to_saved || dec_to_args) begin
                     if (dec_pair_bad) begin
                        trap_valid_o <= 1'b1;
                     end else begin
                        to_saved_ff <= dec_to_saved;
                        r1_ff <= dec_r1;
                        r2_ff <= dec_r2;
                        rf_raddr0_o <= dec_to_saved ? `REG_A0 : dec_r1;
                        rf_raddr1_o <= dec_to_saved ? `REG_A1 : dec_r2;
                        state_ff <= S_PAIR;
                        issue_ready_o <= 1'b0;
                     end
                  end else if (dec_tj_plain || dec_tj_link) begin
                     if (gate_block) begin
                        trap_valid_o <= 1'b1;
                        trap_cause_o <= virtual_mode_i ? VIRTUAL_CAUSE : ILLEGAL_CAUSE;
                     end else if (mode_ff != `MODE_TABLE_JUMP) begin
                        trap_valid_o <= 1'b1;
                     end else begin
                        // Always fetched from memory, never held here
                        link_ff <= dec_tj_link;
                        mem_req_o <= 1'b1;
                        mem_addr_o <= nxt_entry_addr;
                        mem_ifetch_o <= 1'b1;
                        mem_no_trigger_o <= 1'b1;
                        state_ff <= S_TJ;
                        issue_ready_o <= 1'b0;
                     end
                  end else begin
                     trap_valid_o <= 1'b1;
                  end
               end
            end
            S_POP_SP: begin
               // First load one word below the frame top
               new_sp_ff <= rf_rdata0_i + adj_w;
               mem_req_o <= 1'b1;
               mem_addr_o <= rf_rdata0_i + adj_w - BSTEP;
               mem_ifetch_o <= 1'b0;
               mem_no_trigger_o <= 1'b0;
               state_ff <= S_POP_LD;
            end
            S_POP_LD: begin
               if (mem_rvalid_i) begin
                  mem_req_o <= 1'b0;
                  if (mem_fault_i) begin
                     // Loads already done are harmless; a retry redoes them
                     trap_valid_o <= 1'b1;
                     trap_cause_o <= mem_fault_cause_i;
                     trap_value_o <= mem_addr_o;
                     state_ff <= S_IDLE;
                     issue_ready_o <= 1'b1;
                  end else begin
                     rf_we0_o <= 1'b1;
                     rf_waddr0_o <= cur_reg;
                     rf_wdata0_o <= mem_rdata_i;
                     if (sidx_ff == 4'h0) begin
                        if (irq_pending_i) begin
                           replay_o <= 1'b1;
                        end else begin
                           // sp and return land in the same cycle
                           rf_we1_o <= 1'b1;
                           rf_waddr1_o <= `REG_SP;
                           rf_wdata1_o <= new_sp_ff;
                           branch_valid_o <= 1'b1;
                           branch_target_o <= {mem_rdata_i[W-1:1], 1'b0};
                           done_o <= 1'b1;
                        end
                        state_ff <= S_IDLE;
                        issue_ready_o <= 1'b1;
                     end else begin
                        sidx_ff <= sidx_ff - 4'h1;
                        mem_req_o <= 1'b1;
                        mem_addr_o <= mem_addr_o - BSTEP;
                     end
                  end
               end
            end
            S_PAIR: begin
               // Both writes share one cycle, so no half state is seen
               rf_we0_o <= 1'b1;
               rf_we1_o <= 1'b1;
               if (to_saved_ff) begin
                  rf_waddr0_o <= r1_ff;
                  rf_waddr1_o <= r2_ff;
               end else begin
                  rf_waddr0_o <= `REG_A0;
                  rf_waddr1_o <= `REG_A1;
               end
               rf_wdata0_o <= rf_rdata0_i;
               rf_wdata1_o <= rf_rdata1_i;
               done_o <= 1'b1;
               state_ff <= S_IDLE;
               issue_ready_o <= 1'b1;
            end
            S_TJ: begin
               if (mem_rvalid_i) begin
                  mem_req_o <= 1'b0;
                  mem_ifetch_o <= 1'b0;
                  mem_no_trigger_o <= 1'b0;
                  if (mem_fault_i) begin
                     trap_valid_o <= 1'b1;
                     trap_cause_o <= mem_fault_cause_i;
                     trap_value_o <= mem_addr_o;
                  end else begin
                     branch_valid_o <= 1'b1;
                     branch_target_o <= {nxt_entry[W-1:1], 1'b0};
                     if (link_ff) begin
                        rf_we0_o <= 1'b1;
                        rf_waddr0_o <= `REG_RA;
                        rf_wdata0_o <= pc_ff + {{(W-2){1'b0}}, `INSTR_LEN};
                        ras_push_o <= 1'b1;
                     end
                     done_o <= 1'b1;
                  end
                  state_ff <= S_IDLE;
                  issue_ready_o <= 1'b1;
               end
            end
            default: begin
               state_ff <= S_IDLE;
               issue_ready_o <= 1'b1;
               mem_req_o <= 1'b0;
            end
         endcase
      end
   end

endmodule
`default_nettype wire

// *** hdl/tjpm_consts.vh ***
// Shared constants for the table jump and pair move unit
`ifndef TJPM_CONSTS_VH
`define TJPM_CONSTS_VH

// Table control register address and field layout
`define CSR_TABLE_CTRL 12'h017
`define MODE_W 6
`define BASE_ALIGN_BITS 6
`define MODE_TABLE_JUMP 6'h00

// Table geometry
`define TABLE_ENTRIES 256
`define LINK_INDEX_MIN 8'h20
`define SHIFT32 2
`define SHIFT64 3

// Compressed opcode fields
`define OPC_QUAD 2'h2
`define OPC_PAIR_HI 6'h2b
`define OPC_TJ_HI 6'h28
`define PAIR_TO_SAVED 2'h1
`define PAIR_TO_ARGS 2'h3
`define SPEC_REDUCED_MAX 3'h1

// Register numbers
`define REG_RA 5'h01
`define REG_SP 5'h02
`define REG_A0 5'h0a
`define REG_A1 5'h0b

// Pop register list coding
`define RLIST_MIN 4'h4
`define RLIST_ALL 4'hf
`define SREG_ALL 4'hc

// Return address offset of a 16-bit instruction
`define INSTR_LEN 2'h2

`endif

// *** hdl/pair_and_table_decode.v ***
// Decoder for pair move and table jump encodings
`default_nettype none
`include "tjpm_consts.vh"

module pair_and_table_decode (
   input wire [15:0] instr_i,
   input wire reduced_base_i,
   output wire move_args_to_saved_o,
   output wire move_saved_to_args_o,
   output wire table_jump_plain_o,
   output wire table_jump_link_o,
   output wire [7:0] index_o,
   output wire [4:0] first_reg_o,
   output wire [4:0] second_reg_o,
   output wire pair_illegal_o
);

   // Saved specifier to register number: x8, x9, x18..x23
   function [4:0] spec_to_reg;
      input [2:0] spec;
      begin
         spec_to_reg = {(spec[2:1] != 2'h0), (spec[2:1] == 2'h0), spec};
      end
   endfunction

   wire quad_ok; // Low opcode bits match
   wire pair_op; // Pair move group
   wire tj_op; // Table jump group
   wire [2:0] first_saved_specifier;
   wire [2:0] second_saved_specifier;
   wire reduced_bad; // Specifier out of reach of reduced base
   wire same_bad; // Equal targets of a move to saved

   assign quad_ok = (instr_i[1:0] == `OPC_QUAD);
   assign pair_op = quad_ok && (instr_i[15:10] == `OPC_PAIR_HI);
   assign tj_op = quad_ok && (instr_i[15:10] == `OPC_TJ_HI);
   assign first_saved_specifier = instr_i[9:7];
   assign second_saved_specifier = instr_i[4:2];

   assign move_args_to_saved_o = pair_op && (instr_i[6:5] == `PAIR_TO_SAVED);
   assign move_saved_to_args_o = pair_op && (instr_i[6:5] == `PAIR_TO_ARGS);

   // Index below 32 selects the plain form
   assign index_o = instr_i[9:2];
   assign table_jump_plain_o = tj_op && (index_o < `LINK_INDEX_MIN);
   assign table_jump_link_o = tj_op && (index_o >= `LINK_INDEX_MIN);

   assign first_reg_o = spec_to_reg(first_saved_specifier);
   assign second_reg_o = spec_to_reg(second_saved_specifier);

   // Reduced base reaches only x8 and x9
   assign reduced_bad = reduced_base_i && ((first_saved_specifier > `SPEC_REDUCED_MAX) ||
      (second_saved_specifier > `SPEC_REDUCED_MAX));
   assign same_bad = move_args_to_saved_o &&
      (first_saved_specifier == second_saved_specifier);
   assign pair_illegal_o = (move_args_to_saved_o || move_saved_to_args_o) &&
      (reduced_bad || same_bad);

endmodule
`default_nettype wire

// *** testbench/table_jump_and_pair_move_unit_assertions.sv ***
// Port-level checker for the table jump and pair move unit
`default_nettype none
module tjpm_checker #(
   parameter W = 32
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic done_o,
   input wire logic rf_we0_o,
   input wire logic rf_we1_o,
   input wire logic mem_req_o,
   input wire logic [W-1:0] mem_addr_o,
   input wire logic mem_rvalid_i,
   input wire logic mem_ifetch_o,
   input wire logic mem_no_trigger_o,
   input wire logic branch_valid_o,
   input wire logic [W-1:0] branch_target_o,
   input wire logic ras_push_o,
   input wire logic trap_valid_o,
   input wire logic csr_valid_i,
   input wire logic [11:0] csr_addr_i,
   input wire logic csr_ack_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clock_i);
   endclocking
   default disable iff (!resetn_i);

   chk_pair_writes: assert property (rf_we1_o |-> rf_we0_o)
      else $error("second register write without the first");
   chk_entry_no_trig: assert property (mem_req_o && mem_ifetch_o |-> mem_no_trigger_o)
      else $error("entry fetch not marked trigger-free");
   chk_target_even: assert property (branch_valid_o |-> !branch_target_o[0])
      else $error("jump target has bit 0 set");
   chk_link_push: assert property (ras_push_o |-> branch_valid_o && rf_we0_o)
      else $error("return stack push without linking jump");
   chk_req_hold: assert property (mem_req_o && !mem_rvalid_i |=> mem_req_o && $stable(mem_addr_o))
      else $error("request dropped or moved before answer");
   chk_entry_answer: assert property (mem_req_o && mem_rvalid_i && mem_ifetch_o |=>
      branch_valid_o || trap_valid_o)
      else $error("entry answer gave neither jump nor trap");
   chk_csr_ack: assert property (csr_valid_i && csr_addr_i == 12'h017 |=> csr_ack_o)
      else $error("control register access not acknowledged");
   chk_csr_unmapped: assert property (!(csr_valid_i && csr_addr_i == 12'h017) |=> !csr_ack_o)
      else $error("acknowledge without control register access");
   chk_trap_alone: assert property (trap_valid_o |-> !done_o && !branch_valid_o)
      else $error("trap together with completion");

   cov_link: cover property (ras_push_o);
   cov_trap: cover property (trap_valid_o);
   cov_two_writes: cover property (rf_we1_o);
endmodule

bind table_jump_and_pair_move_unit tjpm_checker #(.W(W)) u_tjpm_checker (
   .clock_i(clock_i), .resetn_i(resetn_i), .done_o(done_o), .rf_we0_o(rf_we0_o),
   .rf_we1_o(rf_we1_o), .mem_req_o(mem_req_o), .mem_addr_o(mem_addr_o),
   .mem_rvalid_i(mem_rvalid_i), .mem_ifetch_o(mem_ifetch_o),
   .mem_no_trigger_o(mem_no_trigger_o), .branch_valid_o(branch_valid_o),
   .branch_target_o(branch_target_o), .ras_push_o(ras_push_o), .trap_valid_o(trap_valid_o),
   .csr_valid_i(csr_valid_i), .csr_addr_i(csr_addr_i), .csr_ack_o(csr_ack_o));
`default_nettype wire

// *** testbench/imem_model.sv ***
// Instruction memory model answering table entry and stack fetches
`default_nettype none
module imem_model (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic req_i,
   input wire logic [31:0] addr_i,
   input wire logic slow_i,
   input wire logic [31:0] fault_addr_i,
   output logic rvalid_o,
   output logic [31:0] rdata_o,
   output logic fault_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] wait_ff; // Idle cycles spent on the current request
   // One answer per request, at once or after three waits
   always @(posedge clock_i) begin
      if (!resetn_i) begin
         rvalid_o <= 1'b0;
         rdata_o <= 32'h0;
         fault_o <= 1'b0;
         wait_ff <= 2'h0;
      end else if (req_i && !rvalid_o && (wait_ff == 2'h3 || !slow_i)) begin
         rvalid_o <= 1'b1;
         wait_ff <= 2'h0;
         rdata_o <= addr_i ^ 32'h5a00_0001; // Odd on purpose, bit 0 must be cleared
         fault_o <= (addr_i == fault_addr_i);
      end else begin
         rvalid_o <= 1'b0;
         wait_ff <= (req_i && !rvalid_o) ? wait_ff + 2'h1 : 2'h0;
         // Released lines flip, so stale data never looks valid
         rdata_o <= ~rdata_o;
         fault_o <= ~fault_o;
      end
   end
endmodule
`default_nettype wire

// *** testbench/tb_table_jump_and_pair_move_unit.sv ***
// Self-checking bench for the table jump and pair move unit
`default_nettype none
module tb_table_jump_and_pair_move_unit;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_i, resetn_i, valid, pop, irq, big, lowp, bit2, virt, red, slow;
   logic ready, done, replay, we0, we1, mreq, ifetch, notrig, rvalid, mfault, bv, ras, tv;
   logic cv, cwe, cack, cill, gd, gt, gr, gras, gif, gnt, gack, gill;
   logic [15:0] ins;
   logic [3:0] rlist;
   logic [8:0] adj;
   logic [4:0] ra0, ra1, wa0, wa1, tcause;
   logic [11:0] caddr;
   logic [31:0] pc, wd0, wd1, maddr, rdata, bt, tpc, tval, cwdata, crdata, fa, gaddr;
   logic [31:0] regs [0:31];
   integer fail_count, samples_checked, i;

   table_jump_and_pair_move_unit #(.W(32), .MODE_MASK(6'h01)) u_table_jump_and_pair_move_unit (
      .clock_i(clock_i), .resetn_i(resetn_i), .issue_valid_i(valid), .issue_instr_i(ins),
      .issue_pc_i(pc), .issue_pop_i(pop), .issue_rlist_i(rlist), .issue_stack_adj_i(adj),
      .issue_fault_i(1'b0), .issue_fault_cause_i(5'h00), .issue_ready_o(ready),
      .done_o(done), .replay_o(replay), .reduced_register_base_i(red),
      .data_big_endian_i(big), .lower_priv_i(lowp), .state_enable_bit2_i(bit2),
      .virtual_mode_i(virt), .irq_pending_i(irq), .rf_raddr0_o(ra0), .rf_raddr1_o(ra1),
      .rf_rdata0_i(regs[ra0]), .rf_rdata1_i(regs[ra1]), .rf_we0_o(we0), .rf_waddr0_o(wa0),
      .rf_wdata0_o(wd0), .rf_we1_o(we1), .rf_waddr1_o(wa1), .rf_wdata1_o(wd1),
      .mem_req_o(mreq), .mem_addr_o(maddr), .mem_ifetch_o(ifetch),
      .mem_no_trigger_o(notrig), .mem_rvalid_i(rvalid), .mem_rdata_i(rdata),
      .mem_fault_i(mfault), .mem_fault_cause_i(5'h05), .branch_valid_o(bv),
      .branch_target_o(bt), .ras_push_o(ras), .trap_valid_o(tv), .trap_pc_o(tpc),
      .trap_cause_o(tcause), .trap_value_o(tval), .csr_valid_i(cv), .csr_we_i(cwe),
      .csr_addr_i(caddr), .csr_wdata_i(cwdata), .csr_ack_o(cack), .csr_illegal_o(cill),
      .csr_rdata_o(crdata));

   imem_model u_imem_model (.clock_i(clock_i), .resetn_i(resetn_i), .req_i(mreq),
      .addr_i(maddr), .slow_i(slow), .fault_addr_i(fa), .rvalid_o(rvalid), .rdata_o(rdata),
      .fault_o(mfault));

   // Clock, 50 ns period
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end

   // Register file writes land at the clock edge
   always @(posedge clock_i) begin
      if (we0) regs[wa0] <= wd0;
      if (we1) regs[wa1] <= wd1;
   end

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR at %0t: got %h expected %h", $time, g, e);
      end
   endtask

   // Offer one instruction, collect outcome
   task automatic run(input logic [15:0] op, input logic p, input logic [3:0] rl);
      integer k;
      @(negedge clock_i);
      {ins, pop, rlist, valid} = {op, p, rl, 1'b1};
      {gd, gt, gr, gras} = 4'h0;
      for (k = 0; k < 40 && !(gd | gt | gr); k++) begin
         @(negedge clock_i);
         valid = 1'b0;
         {gd, gt, gr} = {done, tv, replay};
         gras |= ras;
         if (mreq) {gaddr, gif, gnt} = {maddr, ifetch, notrig};
      end
      @(negedge clock_i);
   endtask

   task automatic csr(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(negedge clock_i);
      {cv, cwe, caddr, cwdata} = {1'b1, w, a, d};
      @(negedge clock_i);
      cv = 1'b0;
      {gack, gill} = {cack, cill};
   endtask

   // Table jump and its expected outcome
   task automatic tj(input logic [7:0] ix);
      logic [31:0] e, v, ra;
      ra = regs[1];
      e = 32'h0000_1000 + {22'h0, ix, 2'h0};
      v = e ^ 32'h5a00_0001;
      if (big) v = {v[7:0], v[15:8], v[23:16], v[31:24]};
      run({6'h28, ix, 2'h2}, 1'b0, 4'h4);
      chk(gaddr, e);
      chk(bt, v & 32'hffff_fffe);
      chk({31'h0, gras}, {31'h0, ix >= 8'h20});
      chk(regs[1], ix >= 8'h20 ? 32'h0000_4002 : ra);
      chk({30'h0, gif, gnt}, 32'h3);
   endtask

   task automatic end_sim();
      $display("Checked %0d values, %0d mismatches", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Watchdog
   initial begin
      #(50 * 5000);
      fail_count++;
      end_sim();
   end

   initial begin
      {resetn_i, valid, pop, irq, big, lowp, virt, red, slow, cv, cwe} = 11'h0;
      {ins, rlist, adj, caddr, cwdata, bit2} = {16'h0, 4'h4, 9'h0, 12'h0, 32'h0, 1'b1};
      {pc, fa, fail_count, samples_checked} = {32'h0000_4000, 32'hffff_fff0, 64'h0};
      for (i = 0; i < 32; i++) regs[i] = 32'h100 * i;
      repeat (12) @(posedge clock_i);
      @(negedge clock_i);
      resetn_i = 1'b1;
      // Control register
      csr(1'b0, 12'h017, 32'h0);
      chk({31'h0, gack}, 32'h1);
      chk(crdata, 32'h0);
      csr(1'b1, 12'h017, 32'h0000_12ff);
      csr(1'b0, 12'h017, 32'h0);
      chk(crdata, 32'h0000_12c1);
      csr(1'b0, 12'h018, 32'h0);
      chk({31'h0, gack}, 32'h0);
      run({6'h28, 8'h03, 2'h2}, 1'b0, 4'h4);
      chk({27'h0, tcause}, 32'h2);
      csr(1'b1, 12'h017, 32'h0000_1000);
      $display("test control register done");
      // Index bounds, big endian, slow memory
      tj(8'h1f);
      tj(8'h20);
      tj(8'hff);
      {big, slow} = 2'h3;
      tj(8'h07);
      {big, slow} = 2'h0;
      // Entry fetch fault
      fa = 32'h0000_1024;
      run({6'h28, 8'h09, 2'h2}, 1'b0, 4'h4);
      chk({gt, tcause, tpc, tval}, {1'b1, 5'h05, pc, fa});
      fa = 32'hffff_fff0;
      // State enable gate, plain and virtual
      {lowp, bit2} = 2'h2;
      run({6'h28, 8'h02, 2'h2}, 1'b0, 4'h4);
      chk({gt, tcause}, {1'b1, 5'h02});
      virt = 1'b1;
      run({6'h28, 8'h02, 2'h2}, 1'b0, 4'h4);
      chk({gt, tcause}, {1'b1, 5'h16});
      csr(1'b0, 12'h017, 32'h0);
      chk({gack, gill}, 2'h3);
      {lowp, bit2, virt} = 3'h2;
      $display("test table jumps done");
      // Pair moves, legal and illegal
      run({6'h2b, 3'h0, 2'h1, 3'h7, 2'h2}, 1'b0, 4'h4);
      chk({regs[8], regs[23]}, {32'h0a00, 32'h0b00});
      run({6'h2b, 3'h2, 2'h3, 3'h1, 2'h2}, 1'b0, 4'h4);
      chk({regs[10], regs[11]}, {32'h1200, 32'h0900});
      run({6'h2b, 3'h3, 2'h1, 3'h3, 2'h2}, 1'b0, 4'h4);
      chk({31'h0, gt}, 32'h1);
      red = 1'b1;
      run({6'h2b, 3'h2, 2'h3, 3'h0, 2'h2}, 1'b0, 4'h4);
      chk({31'h0, gt}, 32'h1);
      red = 1'b0;
      $display("test pair moves done");
      // Pop of ra, x8, x9, then one cut by an interrupt
      regs[2] = 32'h2000;
      adj = 9'd16;
      run(16'h0, 1'b1, 4'h6);
      chk({regs[9], regs[8]}, {32'h5a00_200d, 32'h5a00_2009});
      chk({regs[1], regs[2]}, {32'h5a00_2005, 32'h2010});
      chk(bt, 32'h5a00_2004);
      irq = 1'b1;
      run(16'h0, 1'b1, 4'h4);
      chk({gr, gd, regs[2]}, {2'h2, 32'h2010});
      irq = 1'b0;
      $display("test pop and return done");
      end_sim();
   end
endmodule
`default_nettype wire
